// ---- hw/psp_defs.svh ----
/*
  register indices, field positions, reset values and pattern words
  for the adc output post-processing block.
  assumes the includer wraps it in its own compile unit.
*/
`ifndef PSP_DEFS_SVH
`define PSP_DEFS_SVH
// register indices, byte address is four times the index
`define PSP_IDX_GAIN_OFS 8'h13
`define PSP_IDX_OFS_COPY 8'h14
`define PSP_IDX_PAT_HPF  8'h15
`define PSP_IDX_CTRL     8'h40
`define PSP_IDX_STATUS   8'h41
`define PSP_IDX_COUNT    8'h42
// field positions
`define PSP_GAIN_MSB     15
`define PSP_GAIN_LSB     11
`define PSP_OFS_MSB      9
`define PSP_PRBS1_BIT    15
`define PSP_PAT1_MSB     11
`define PSP_PAT1_LSB     9
`define PSP_PAT2_MSB     8
`define PSP_PAT2_LSB     6
`define PSP_RND_BIT      5
`define PSP_K_MSB        4
`define PSP_K_LSB        1
`define PSP_HPF_EN_BIT   0
`define PSP_CTL_GAIN_BIT 0
`define PSP_CTL_OFS_BIT  1
`define PSP_CTL_PSEL_BIT 2
`define PSP_STS_MISM_BIT 16
// reset values and arithmetic constants
`define PSP_REG_RESET    16'h0000
`define PSP_GAIN_FRAC    12
`define PSP_PRBS_SEED    23'h7fffff
// pattern words
`define PSP_WORD_SYNC    14'h3f80
`define PSP_WORD_ALT     14'h2aaa
`define PSP_WORD_ONES    14'h3fff
`define PSP_WORD_ZEROS   14'h0000
// bus responses
`define PSP_RESP_OKAY    2'b00
`define PSP_RESP_SLVERR  2'b10
`endif

// ---- hw/psp_hpf.sv ----
/*
  first-order high-pass filter for one channel, registered output.
  assumes a one-cycle sample strobe on aclk and k between 2 and 10.
*/
`timescale 1ns/10ps
`default_nettype none
module psp_hpf #(parameter int FRAC = 12)
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  psp_hpf_if.flt                   cfg,
  input  wire logic                in_valid,
  input  wire psp_pkg::psp_smp_type in_data,
  output var  psp_pkg::psp_smp_type out_data
);
  localparam logic signed [31:0] HALF = 32'sh1 <<< (FRAC - 1);
  logic signed [31:0] x1_r;
  logic signed [31:0] y1_r;
  logic signed [31:0] xs;
  logic signed [31:0] s;
  logic signed [31:0] y_nxt;
  logic signed [31:0] r;
  // 1/(1+2^-k) as a three-term series, error below 2^-3k
  always_comb
  begin
    xs    = 32'(in_data) <<< FRAC;
    s     = xs - x1_r + y1_r;
    y_nxt = s - (s >>> cfg.k) + (s >>> {cfg.k, 1'b0});
    r     = cfg.rnd ? y_nxt + HALF : y_nxt;
  end
  // history and output, bypass when disabled
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      x1_r     <= '0;
      y1_r     <= '0;
      out_data <= '0;
    end
    else if (in_valid)
    begin
      x1_r <= xs;
      y1_r <= cfg.en ? y_nxt : 32'sh0;
      out_data <= cfg.en ? psp_pkg::psp_sat14(r >>> FRAC)
                         : in_data;
    end
  end
endmodule
`default_nettype wire

// ---- hw/psp_hpf_if.sv ----
/*
  high-pass filter settings shared by the four channel filters.
  assumes the top drives it from its configuration register.
*/
`timescale 1ns/10ps
`default_nettype none
interface psp_hpf_if;
  logic       en;
  logic [3:0] k;
  logic       rnd;
  modport ctl (output en, k, rnd);
  modport flt (input en, k, rnd);
endinterface
`default_nettype wire

// ---- hw/psp_patgen.sv ----
/*
  test-pattern substitution for one serial output, registered output.
  assumes one step pulse per sample carrying processed data.
*/
`timescale 1ns/10ps
`default_nettype none
`include "psp_defs.svh"
module psp_patgen #(parameter logic [13:0] CUSTOM = 14'h0f0f)
(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 step,
  input  wire psp_pkg::psp_pat_type code,
  input  wire logic                 prbs_en,
  input  wire psp_pkg::psp_smp_type data_in,
  output var  psp_pkg::psp_smp_type data_out
);
  logic [22:0] lfsr_r;
  logic [13:0] ramp_r;
  logic        tog_r;
  logic [13:0] sel;
  // pattern decode, prbs first, normal passes data
  always_comb
  begin
    case (code)
      psp_pkg::PSP_PAT_NORMAL: sel = data_in;
      psp_pkg::PSP_PAT_SYNC:   sel = `PSP_WORD_SYNC;
      psp_pkg::PSP_PAT_ALT:    sel = `PSP_WORD_ALT;
      psp_pkg::PSP_PAT_CUSTOM: sel = CUSTOM;
      psp_pkg::PSP_PAT_ONES:   sel = `PSP_WORD_ONES;
      psp_pkg::PSP_PAT_TOGGLE: sel = tog_r ? `PSP_WORD_ONES : `PSP_WORD_ZEROS;
      psp_pkg::PSP_PAT_ZEROS:  sel = `PSP_WORD_ZEROS;
      psp_pkg::PSP_PAT_RAMP:   sel = ramp_r;
      default:                 sel = data_in;
    endcase
    if (prbs_en)
      sel = lfsr_r[13:0];
  end
  // generators advance once per sample
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lfsr_r   <= `PSP_PRBS_SEED;
      ramp_r   <= '0;
      tog_r    <= 1'b0;
      data_out <= '0;
    end
    else if (step)
    begin
      lfsr_r   <= {lfsr_r[21:0], lfsr_r[22] ^ lfsr_r[17]};
      ramp_r   <= ramp_r + 14'h0001;
      tog_r    <= ~tog_r;
      data_out <= sel;
    end
  end
endmodule
`default_nettype wire

// ---- hw/psp_pkg.sv ----
/*
  types and the saturation helper shared by the post-processing files.
  assumes 14-bit two's-complement samples.
*/
package psp_pkg;
  typedef logic signed [13:0] psp_smp_type;
  // test-pattern codes
  typedef enum logic [2:0] {
    PSP_PAT_NORMAL = 3'b000,
    PSP_PAT_SYNC   = 3'b001,
    PSP_PAT_ALT    = 3'b010,
    PSP_PAT_CUSTOM = 3'b011,
    PSP_PAT_ONES   = 3'b100,
    PSP_PAT_TOGGLE = 3'b101,
    PSP_PAT_ZEROS  = 3'b110,
    PSP_PAT_RAMP   = 3'b111
  } psp_pat_type;
  // clamp a wide value to the 14-bit sample range
  function automatic psp_smp_type psp_sat14(input logic signed [31:0] v);
    if (v > 32'sh00001fff)
      return 14'h1fff;
    else if (v < -32'sh00002000)
      return 14'h2000;
    else
      return v[13:0];
  endfunction
endpackage

// ---- hw/psp_post_proc.sv ----
/*
  adc output post-processing top: axi4-lite register slave, high-pass
  filters on channels 1 to 4, channel 4 gain and offset, and test
  patterns on serial outputs 1 to 4.
  assumes samples arrive on aclk from adc logic with a one-cycle strobe
  and the serializer takes out_word when out_valid is high.
*/
// Design decision made here: the AXI4-Lite interface to the registers.
// Overview of operation
// - gain enabled: channel 4 scaled by gain code times 0.2 dB.
// - offset enabled: signed 10-bit offset added, step of one 14-bit lsb.
// - per-output select: set prbs bit replaces that output with prbs.
// - per-output select: output 1 code bits 11-9, output 2 bits 8-6.
// - codes: normal, sync, alternate, custom, ones, toggle, zeros, ramp.
// - filter output truncated when round bit 0, rounded when 1.
// - filter is y = 2^k/(2^k+1) times (x - old x + old y).
// - filter bypassed on channels 1 to 4 when bit 0 clear.
// - all fields reset to zero: normal data, no gain, offset, filter.
`timescale 1ns/10ps
`default_nettype none
`include "psp_defs.svh"
module psp_post_proc #(
  parameter int          AW          = 12,
  parameter int          FRAC        = 12,
  parameter logic [13:0] CUSTOM_WORD = 14'h0f0f
)
(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [AW-1:0]        awaddr,
  input  wire logic [2:0]           awprot,
  input  wire logic                 awvalid,
  output var  logic                 awready,
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  input  wire logic                 wvalid,
  output var  logic                 wready,
  output var  logic [1:0]           bresp,
  output var  logic                 bvalid,
  input  wire logic                 bready,
  input  wire logic [AW-1:0]        araddr,
  input  wire logic [2:0]           arprot,
  input  wire logic                 arvalid,
  output var  logic                 arready,
  output var  logic [31:0]          rdata,
  output var  logic [1:0]           rresp,
  output var  logic                 rvalid,
  input  wire logic                 rready,
  input  wire logic                 smp_valid,
  input  wire psp_pkg::psp_smp_type smp_in [4],
  output wire psp_pkg::psp_smp_type out_word [4],
  output var  logic                 out_valid
);
  // ==========================================================
  // declarations
  logic [15:0]          gain_ofs_r;
  logic [15:0]          ofs_copy_r;
  logic [15:0]          pat_hpf_r;
  logic [2:0]           ctrl_r;
  logic [31:0]          count_r;
  logic [AW-1:0]        waddr_r;
  logic                 aw_got_r;
  logic [31:0]          wdata_r;
  logic [3:0]           wstrb_r;
  logic                 w_got_r;
  logic                 commit;
  logic                 v1_r;
  logic                 v2_r;
  psp_pkg::psp_smp_type hpf_out [4];
  psp_pkg::psp_smp_type proc [4];
  psp_pkg::psp_pat_type code [4];
  logic [3:0]           prbs_en;
  logic [4:0]           gain_code;
  logic signed [9:0]    ofs_val;
  logic signed [31:0]   prod_v;
  logic signed [31:0]   g_v;
  logic signed [31:0]   o_v;
  logic                 gain_en;
  logic                 ofs_en;
  logic                 psel;

  // ==========================================================
  // gain table: 10^(n*0.01) in unsigned q4.12, n = 0..31
  localparam logic [15:0] GAIN_TAB [32] = '{
    16'h1000, 16'h105f, 16'h10c1, 16'h1125,
    16'h118b, 16'h11f4, 16'h125f, 16'h12cc,
    16'h133c, 16'h13af, 16'h1425, 16'h149d,
    16'h1518, 16'h1595, 16'h1616, 16'h169a,
    16'h1721, 16'h17aa, 16'h1838, 16'h18c8,
    16'h195c, 16'h19f3, 16'h1a8e, 16'h1b2c,
    16'h1bce, 16'h1c74, 16'h1d1d, 16'h1dcb,
    16'h1e7d, 16'h1f33, 16'h1fed, 16'h20ab
  };

  // ==========================================================
  // helper functions
  // word index of an aligned address inside the decoded window
  function automatic logic [7:0] word_idx(input logic [AW-1:0] a);
    return a[9:2];
  endfunction

  // address is aligned and lands on a mapped register
  function automatic logic mapped(input logic [AW-1:0] a);
    logic [7:0] i;
    i = a[9:2];
    if (a[1:0] != 2'b00 || (a >> 10) != '0)
      return 1'b0;
    return i == `PSP_IDX_GAIN_OFS || i == `PSP_IDX_OFS_COPY ||
           i == `PSP_IDX_PAT_HPF || i == `PSP_IDX_CTRL ||
           i == `PSP_IDX_STATUS || i == `PSP_IDX_COUNT;
  endfunction

  // merge the two low byte lanes into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
    logic [15:0] m;
    m = old;
    if (s[0])
      m[7:0] = d[7:0];
    if (s[1])
      m[15:8] = d[15:8];
    return m;
  endfunction

  // ==========================================================
  // write address and data capture, either order
  assign awready = ~aw_got_r;
  assign wready  = ~w_got_r;
  assign commit  = aw_got_r & w_got_r & ~bvalid;

  // address side
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_r <= 1'b0;
      waddr_r  <= '0;
    end
    else if (awvalid && !aw_got_r)
    begin
      aw_got_r <= 1'b1;
      waddr_r  <= awaddr;
    end
    else if (commit)
      aw_got_r <= 1'b0;
  end

  // data side
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_got_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end
    else if (wvalid && !w_got_r)
    begin
      w_got_r <= 1'b1;
      wdata_r <= wdata;
      wstrb_r <= wstrb;
    end
    else if (commit)
      w_got_r <= 1'b0;
  end

  // write response one cycle after both halves are held
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp  <= `PSP_RESP_OKAY;
    end
    else if (commit)
    begin
      bvalid <= 1'b1;
      bresp  <= mapped(waddr_r) ? `PSP_RESP_OKAY : `PSP_RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // ==========================================================
  // configuration registers, all cleared by reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gain_ofs_r <= `PSP_REG_RESET;
      ofs_copy_r <= `PSP_REG_RESET;
      pat_hpf_r  <= `PSP_REG_RESET;
      ctrl_r     <= '0;
    end
    else if (commit && mapped(waddr_r))
    begin
      case (word_idx(waddr_r))
        `PSP_IDX_GAIN_OFS: gain_ofs_r <= merge16(gain_ofs_r, wdata_r, wstrb_r);
        `PSP_IDX_OFS_COPY: ofs_copy_r <= merge16(ofs_copy_r, wdata_r, wstrb_r);
        `PSP_IDX_PAT_HPF:  pat_hpf_r  <= merge16(pat_hpf_r, wdata_r, wstrb_r);
        `PSP_IDX_CTRL:
        begin
          if (wstrb_r[0])
            ctrl_r <= wdata_r[2:0];
        end
        default:
        begin
          ctrl_r <= ctrl_r;
        end
      endcase
    end
  end

  // ==========================================================
  // read channel, data one cycle after the address is taken
  assign arready = ~rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= `PSP_RESP_OKAY;
    end
    else if (arvalid && !rvalid)
    begin
      rvalid <= 1'b1;
      rresp  <= mapped(araddr) ? `PSP_RESP_OKAY : `PSP_RESP_SLVERR;
      rdata  <= '0;
      if (mapped(araddr))
      begin
        case (word_idx(araddr))
          `PSP_IDX_GAIN_OFS: rdata <= {16'h0000, gain_ofs_r};
          `PSP_IDX_OFS_COPY: rdata <= {16'h0000, ofs_copy_r};
          `PSP_IDX_PAT_HPF:  rdata <= {16'h0000, pat_hpf_r};
          `PSP_IDX_CTRL:     rdata <= {29'h00000000, ctrl_r};
          `PSP_IDX_STATUS:
          begin
            rdata <= {15'h0000,
                      gain_ofs_r[9:0] != ofs_copy_r[9:0],
                      2'b00, out_word[3]};
          end
          `PSP_IDX_COUNT:    rdata <= count_r;
          default:           rdata <= '0;
        endcase
      end
    end
    else if (rready)
      rvalid <= 1'b0;
  end

  // ==========================================================
  // field decode
  assign gain_en   = ctrl_r[`PSP_CTL_GAIN_BIT];
  assign ofs_en    = ctrl_r[`PSP_CTL_OFS_BIT];
  assign psel      = ctrl_r[`PSP_CTL_PSEL_BIT];
  assign gain_code = gain_ofs_r[`PSP_GAIN_MSB:`PSP_GAIN_LSB];
  // working copy of the offset is the gain/offset register
  assign ofs_val   = gain_ofs_r[`PSP_OFS_MSB:0];

  // ==========================================================
  // high-pass filters, one per channel, shared settings
  psp_hpf_if hcfg ();
  assign hcfg.en  = pat_hpf_r[`PSP_HPF_EN_BIT];
  assign hcfg.k   = pat_hpf_r[`PSP_K_MSB:`PSP_K_LSB];
  assign hcfg.rnd = pat_hpf_r[`PSP_RND_BIT];

  for (genvar c = 0; c < 4; c++)
  begin : g_hpf
    psp_hpf #(.FRAC(FRAC)) u_hpf
    (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .cfg      (hcfg),
      .in_valid (smp_valid),
      .in_data  (smp_in[c]),
      .out_data (hpf_out[c])
    );
  end

  // ==========================================================
  // channel 4 gain then offset, other channels pass
  always_comb
  begin
    prod_v = 32'(hpf_out[3]) * $signed(32'(GAIN_TAB[gain_code]));
    g_v    = gain_en ? (prod_v >>> `PSP_GAIN_FRAC)
                     : 32'(hpf_out[3]);
    o_v    = ofs_en ? g_v + 32'(ofs_val) : g_v;
    proc[0] = hpf_out[0];
    proc[1] = hpf_out[1];
    proc[2] = hpf_out[2];
    proc[3] = psp_pkg::psp_sat14(o_v);
  end

  // ==========================================================
  // per-output pattern codes; outputs 3 and 4 carry data or prbs only
  always_comb
  begin
    code[0] = psp_pkg::PSP_PAT_NORMAL;
    code[1] = psp_pkg::PSP_PAT_NORMAL;
    code[2] = psp_pkg::PSP_PAT_NORMAL;
    code[3] = psp_pkg::PSP_PAT_NORMAL;
    if (psel)
    begin
      code[0] = psp_pkg::psp_pat_type'(
                  pat_hpf_r[`PSP_PAT1_MSB:`PSP_PAT1_LSB]);
      code[1] = psp_pkg::psp_pat_type'(
                  pat_hpf_r[`PSP_PAT2_MSB:`PSP_PAT2_LSB]);
    end
    for (int i = 0; i < 4; i++)
      prbs_en[i] = psel & pat_hpf_r[`PSP_PRBS1_BIT - i];
  end

  // ==========================================================
  // sample strobe pipeline: filter stage, then pattern stage
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      v1_r <= 1'b0;
      v2_r <= 1'b0;
    end
    else
    begin
      v1_r <= smp_valid;
      v2_r <= v1_r;
    end
  end
  assign out_valid = v2_r;

  // delivered sample count for software
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count_r <= '0;
    else if (v2_r)
      count_r <= count_r + 32'h00000001;
  end

  // ==========================================================
  // pattern substitution, one generator per output
  for (genvar o = 0; o < 4; o++)
  begin : g_pat
    psp_patgen #(.CUSTOM(CUSTOM_WORD)) u_pat
    (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .step     (v1_r),
      .code     (code[o]),
      .prbs_en  (prbs_en[o]),
      .data_in  (proc[o]),
      .data_out (out_word[o])
    );
  end
endmodule
`default_nettype wire

// ---- tb/psp_post_proc_assertions.sv ----
/*
  checker on the post-processing top ports.
  assumes one clock domain and a bind onto psp_post_proc.
*/
`timescale 1ns/10ps
`default_nettype none
module psp_post_proc_chk
(
  input wire logic                 aclk,
  input wire logic                 aresetn,
  input wire logic                 awvalid,
  input wire logic                 awready,
  input wire logic                 wvalid,
  input wire logic                 wready,
  input wire logic [1:0]           bresp,
  input wire logic                 bvalid,
  input wire logic                 bready,
  input wire logic                 arvalid,
  input wire logic                 arready,
  input wire logic [31:0]          rdata,
  input wire logic                 rvalid,
  input wire logic                 rready,
  input wire logic                 smp_valid,
  input wire psp_pkg::psp_smp_type smp_in [4],
  input wire psp_pkg::psp_smp_type out_word [4],
  input wire logic                 out_valid
);
  // ======================================
  // helpers and sequences
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic cfg_zero_r;
  // high from reset until the first write address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cfg_zero_r <= 1'b1;
    else if (awvalid && awready)
      cfg_zero_r <= 1'b0;
  end
  sequence s_wr_both;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_clean_smp;
    cfg_zero_r && smp_valid;
  endsequence
  // ======================================
  // assertions
  chk_reset_quiet: assert property ($rose(aresetn) |->
    !out_valid && !bvalid && !rvalid && out_word[0] == 14'h0000)
    else $error("outputs not idle after reset");
  chk_pass_first: assert property (s_clean_smp |->
    ##2 out_word[0] == $past(smp_in[0], 2))
    else $error("channel 1 altered with stages off");
  chk_pass_fourth: assert property (s_clean_smp |->
    ##2 out_word[3] == $past(smp_in[3], 2))
    else $error("channel 4 altered after reset");
  chk_out_timing: assert property (smp_valid |-> ##2 out_valid)
    else $error("no output strobe two cycles after sample");
  chk_out_cause: assert property (out_valid |-> $past(smp_valid, 2))
    else $error("output strobe without sample");
  chk_word_hold: assert property ($past(aresetn) && !out_valid |->
    $stable(out_word[0]) && $stable(out_word[3]))
    else $error("output word moved without strobe");
  chk_wr_answer: assert property (s_wr_both && (!bvalid || bready) |->
    ##2 bvalid)
    else $error("write response missing");
  chk_resp_hold: assert property (bvalid && !bready |=>
    bvalid && $stable(bresp))
    else $error("write response dropped early");
  chk_read_hold: assert property (rvalid && !rready |=>
    rvalid && $stable(rdata))
    else $error("read data dropped early");
  chk_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read response missing");
  chk_read_cause: assert property ($rose(rvalid) |->
    $past(arvalid && arready))
    else $error("read response without address");
endmodule
bind psp_post_proc psp_post_proc_chk i_psp_post_proc_chk
(
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bresp,
  .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready,
  .smp_valid, .smp_in, .out_word, .out_valid
);
`default_nettype wire

// ---- tb/psp_rx_model.sv ----
/*
  receiver model: captures each output word set with its strobe.
  assumes the strobe and words share aclk.
*/
`timescale 1ns/10ps
`default_nettype none
module psp_rx_model
(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 out_valid,
  input  wire psp_pkg::psp_smp_type out_word [4],
  output var  logic [13:0]          rx_word [4],
  output var  logic [15:0]          rx_count
);
  // ======================================
  // capture, no back-pressure
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rx_count <= 16'h0000;
    else if (out_valid)
    begin
      for (int i = 0; i < 4; i++)
        rx_word[i] <= out_word[i];
      rx_count <= rx_count + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ---- tb/tb_psp_post_proc.sv ----
/*
  bench for the post-processing top: bus and sample tasks, tests.
  assumes the checker binds itself onto the top.
*/
`timescale 1ns/10ps
`default_nettype none
`include "psp_defs.svh"
module tb_psp_post_proc;
  localparam logic [11:0] A_GO = 12'h04c;
  localparam logic [11:0] A_OC = 12'h050;
  localparam logic [11:0] A_PH = 12'h054;
  localparam logic [11:0] A_CT = 12'h100;
  localparam logic [13:0] CW   = 14'h0f0f;
  logic                 aclk, aresetn, smp_valid, out_valid;
  logic                 awvalid, awready, wvalid, wready, bvalid;
  logic                 bready, arvalid, arready, rvalid, rready;
  logic [11:0]          awaddr, araddr;
  logic [2:0]           awprot, arprot;
  logic [3:0]           wstrb;
  logic [31:0]          wdata, rdata;
  logic [1:0]           bresp, rresp;
  psp_pkg::psp_smp_type smp_in [4];
  psp_pkg::psp_smp_type out_word [4];
  logic [13:0]          rx_word [4];
  logic [15:0]          rx_count;
  logic [13:0]          p0;
  int                   fail_count, compares;
  // ======================================
  // design, receiver, clock
  psp_post_proc #(.CUSTOM_WORD(CW)) i_psp_post_proc
  (
    .aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .smp_valid, .smp_in, .out_word, .out_valid
  );
  psp_rx_model i_psp_rx_model
  (
    .aclk, .aresetn, .out_valid, .out_word, .rx_word, .rx_count
  );
  // 100 mhz
  always #5 aclk = ~aclk;
  // ======================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic near(input string nm, input int e,
                      input psp_pkg::psp_smp_type g, input int t);
    int d;
    d = int'(g) - e;
    compares++;
    if ($isunknown(g) || d > t || d < -t)
    begin
      fail_count++;
      $display("Error %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      n++;
    end
    while (!(bvalid && bready) && n < 50);
    if (!(bvalid && bready))
      fail_count++;
    chk("bresp", e, bresp);
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      n++;
    end
    while (!(rvalid && rready) && n < 50);
    if (!(rvalid && rready))
      fail_count++;
    chk("rdata", e, rdata);
    chk("rresp", er, rresp);
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  // channels 1 to 3 get a, channel 4 gets b
  task automatic smp(input logic [13:0] a, b);
    int n;
    logic [15:0] c0;
    n = 0;
    c0 = rx_count;
    for (int i = 0; i < 3; i++)
      smp_in[i] <= a;
    smp_in[3] <= b;
    smp_valid <= 1'b1;
    @(posedge aclk);
    smp_valid <= 1'b0;
    while (rx_count == c0 && n < 20)
    begin
      @(posedge aclk);
      n++;
    end
    if (rx_count == c0)
      fail_count++;
  endtask
  function automatic logic [13:0] pexp(input int c, input logic [13:0] d);
    case (c)
      1: return `PSP_WORD_SYNC;
      2: return `PSP_WORD_ALT;
      3: return CW;
      4: return `PSP_WORD_ONES;
      6: return `PSP_WORD_ZEROS;
      default: return d;
    endcase
  endfunction
  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ======================================
  // tests
  initial
  begin
    {aclk, aresetn, smp_valid, awvalid, wvalid, bready} = '0;
    {arvalid, rready, awaddr, araddr, awprot, arprot} = '0;
    {wstrb, wdata} = '0;
    smp_in = '{default: 14'h0000};
    fail_count = 0;
    compares = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    smp(14'h1234, 14'h2abc);
    chk("out1", 14'h1234, rx_word[0]);
    chk("out4", 14'h2abc, rx_word[3]);
    rd(A_GO, 32'h0, 2'b00);
    rd(A_OC, 32'h0, 2'b00);
    rd(A_PH, 32'h0, 2'b00);
    $display("test reset finished");
    wr(A_GO, 32'h0000f805, 2'b00);
    rd(A_GO, 32'h0000f805, 2'b00);
    wr(A_OC, 32'hffff0005, 2'b00);
    rd(A_OC, 32'h00000005, 2'b00);
    rd(12'h104, 32'h00002abc, 2'b00);
    rd(12'h108, 32'h00000001, 2'b00);
    wr(12'h00c, 32'h1, 2'b10);
    rd(12'h00c, 32'h0, 2'b10);
    $display("test registers finished");
    wr(A_GO, 32'h00002800, 2'b00);
    wr(A_CT, 32'h1, 2'b00);
    smp(14'd500, 14'd1000);
    near("gain", 1122, rx_word[3], 2);
    chk("out1", 14'd500, rx_word[0]);
    wr(A_GO, 32'h0000f800, 2'b00);
    smp(14'd500, 14'd3000);
    near("gain", 6125, rx_word[3], 3);
    wr(A_GO, 32'h00000200, 2'b00);
    wr(A_OC, 32'h00000200, 2'b00);
    wr(A_CT, 32'h2, 2'b00);
    smp(14'd500, 14'd100);
    chk("offset", 14'h3e64, rx_word[3]);
    wr(A_GO, 32'h000001ff, 2'b00);
    wr(A_OC, 32'h000001ff, 2'b00);
    smp(14'd500, 14'h1f40);
    chk("offset", 14'h1fff, rx_word[3]);
    wr(A_CT, 32'h0, 2'b00);
    smp(14'd500, 14'd100);
    chk("out4", 14'd100, rx_word[3]);
    $display("test gain offset finished");
    wr(A_CT, 32'h4, 2'b00);
    for (int c = 0; c < 8; c++)
    begin
      wr(A_PH, 32'(c << 9) | 32'((7 - c) << 6), 2'b00);
      smp(14'h0155, 14'h0155);
      p0 = rx_word[0];
      smp(14'h0155, 14'h0155);
      if (c == 5)
        chk("toggle", 14'h3fff, rx_word[0] ^ p0);
      else if (c == 7)
        chk("ramp", 14'(p0 + 14'h0001), rx_word[0]);
      else
        chk("pat1", pexp(c, 14'h0155), rx_word[0]);
      if (c != 0 && c != 2)
        chk("pat2", pexp(7 - c, 14'h0155), rx_word[1]);
      chk("out3", 14'h0155, rx_word[2]);
    end
    wr(A_PH, 32'h0000a000, 2'b00);
    smp(14'h0155, 14'h0155);
    p0 = rx_word[0];
    smp(14'h0155, 14'h0155);
    chk("prbs", 1'b1, rx_word[0] !== p0);
    chk("out2", 14'h0155, rx_word[1]);
    wr(A_CT, 32'h0, 2'b00);
    smp(14'h0155, 14'h0155);
    chk("out1", 14'h0155, rx_word[0]);
    $display("test patterns finished");
    wr(A_PH, 32'h0, 2'b00);
    smp(14'h0, 14'h0);
    wr(A_PH, 32'h00000015, 2'b00);
    smp(14'd300, 14'd300);
    chk("hpf", 14'd299, rx_word[0]);
    chk("hpf4", 14'd299, rx_word[3]);
    smp(14'd300, 14'd300);
    near("hpf", 299, rx_word[0], 1);
    wr(A_PH, 32'h0, 2'b00);
    smp(14'h3ffb, 14'h0);
    chk("bypass", 14'h3ffb, rx_word[0]);
    smp(14'h0, 14'h0);
    wr(A_PH, 32'h00000035, 2'b00);
    smp(14'd300, 14'd300);
    chk("hpf", 14'd300, rx_word[0]);
    $display("test filter finished");
    finish_test();
  end
  // cut a hang short
  initial
  begin
    #100000;
    fail_count++;
    finish_test();
  end
endmodule
`default_nettype wire
